// file: sfcf_pkg.sv
package sfcf_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;

    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_MAIN_READ   = 8'hd2;
    localparam logic [7:0] OP_CONT_LEGACY = 8'he8;
    localparam logic [7:0] OP_CONT_LF     = 8'h03;
    localparam logic [7:0] OP_CONT_HF     = 8'h0b;
    localparam logic [7:0] OP_BUF_READ_LF = 8'hd1;
    localparam logic [7:0] OP_BUF_READ    = 8'hd4;
    localparam logic [7:0] OP_BUF_WRITE   = 8'h84;
    localparam logic [7:0] OP_PROG_ERASE  = 8'h83;
    localparam logic [7:0] OP_PROG_NOERA  = 8'h88;
    localparam logic [7:0] OP_PAGE_ERASE  = 8'h81;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] OP_SECT_ERASE  = 8'h7c;
    localparam logic [7:0] OP_PROG_THRU   = 8'h82;
    localparam logic [7:0] OP_STATUS      = 8'hd7;
    localparam logic [7:0] OP_IDENT       = 8'h9f;
    localparam logic [7:0] OP_CFG_PREFIX  = 8'h3d;
    // second to fourth bytes of the multi-byte sequences
    localparam logic [23:0] SEQ_CFG_TAIL  = 24'h2a_80_a6;
    localparam logic [23:0] SEQ_CHIP_TAIL = 24'h94_80_9a;

    // ----------------------------------------
    // identification (values arbitrary)
    // ----------------------------------------
    localparam logic [7:0] ID_MANUFACTURER = 8'h5a;
    localparam logic [2:0] ID_FAMILY       = 3'h5;
    localparam logic [4:0] ID_DENSITY      = 5'h0a;
    localparam logic [2:0] ID_CELL_TECH    = 3'h2;
    localparam logic [4:0] ID_VERSION      = 5'h01;
    localparam logic [7:0] ID_EXT_LENGTH   = 8'h00;
    localparam logic [1:0] ID_LAST_INDEX   = 2'h3;

    // ----------------------------------------
    // status byte layout
    // ----------------------------------------
    localparam int         ST_READY_BIT   = 7;
    localparam int         ST_COMP_BIT    = 6;
    localparam int         ST_DENS_LSB    = 2;
    localparam int         ST_PROTECT_BIT = 1;
    localparam int         ST_PSIZE_BIT   = 0;
    localparam logic [3:0] ST_DENSITY     = 4'h7;

    typedef enum logic [1:0] {
        BUSY_ERASE    = 2'b00,
        BUSY_TRANSFER = 2'b01,
        BUSY_PROTECT  = 2'b10
    } sfcf_busy_t;

    typedef enum logic [3:0] {
        OPC_NONE       = 4'b0000,
        OPC_MAIN_READ  = 4'b0001,
        OPC_CONT_READ  = 4'b0010,
        OPC_BUF_READ   = 4'b0011,
        OPC_BUF_WRITE  = 4'b0100,
        OPC_PROG_ERASE = 4'b0101,
        OPC_PROG_NOERA = 4'b0110,
        OPC_PAGE_ERASE = 4'b0111,
        OPC_BLK_ERASE  = 4'b1000,
        OPC_SECT_ERASE = 4'b1001,
        OPC_PROG_THRU  = 4'b1010,
        OPC_CHIP_ERASE = 4'b1011
    } sfcf_op_t;

    typedef struct packed {
        sfcf_op_t op;
        logic     page_256;
    } sfcf_cmd_t;

endpackage

// file: sfcf_top.sv
// Behaviour
// - page size option is one-time: starts at 264 bytes, once 256 never back.
// - page size option programmed only by exact bytes 3D, 2A, 80, A6.
// - chip select rising after that sequence starts timed program; status shows busy.
// - new 256-byte page size takes effect only after the next power cycle.
// - after opcode 9F the identification bytes follow on serial output.
// - order is manufacturer, two device bytes, then extended length byte.
// - extended length is zero and no extended data follows.
// - chip select high ends any response at once, output released.
// - device byte one is family and density; byte two cell tech and version.
// - during erase, buffer read and write, status and identification are accepted.
// - during transfer cycles only status and identification allowed; during program cycles only status.
// - read opcodes D2, E8, 03, 0B, D1, D4 decoded.
// - program and erase opcodes 84, 83, 88, 81, 50, 7C, 82 and chip erase decoded.
// - opcode D7 sends status msb first, repeated with fresh contents.
// - status bit 7 is one when ready, zero while busy.
// - status bit 0 is one for 256-byte pages, zero for 264.
`timescale 1ns/1ps

module sfcf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              do_wr = in_valid && in_ready;
    wire              do_rd = out_valid && out_ready;

    assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(do_wr);
            rd_ptr <= rd_ptr + (AW+1)'(do_rd);
        end
    end
endmodule // sfcf_fifo

module sfcf_top #(
    parameter int TP_NS = 4000000
) (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                cs_n,
    input  wire logic                sck,
    input  wire logic                si,
    output logic                     so,
    output logic                     so_oe,
    input  wire logic                array_busy,
    input  wire sfcf_pkg::sfcf_busy_t busy_kind,
    input  wire logic                comp_result,
    input  wire logic                protect_on,
    input  wire logic                nv_pow2,
    output logic                     nv_pow2_write,
    output logic                     page_256,
    output logic                     busy,
    output logic                     cmd_valid,
    output sfcf_pkg::sfcf_cmd_t      cmd,
    output logic                     cmd_reject,
    output logic                     rx_valid,
    input  wire logic                rx_ready,
    output logic [7:0]               rx_data,
    output logic                     rx_overflow
);
    localparam int TP_CYCLES = TP_NS / sfcf_pkg::CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        M_OPC  = 3'b000,
        M_BODY = 3'b001,
        M_TX   = 3'b010,
        M_CFG  = 3'b011,
        M_CE   = 3'b100,
        M_SKIP = 3'b101
    } sfcf_mode_t;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] cs_s;
    logic [2:0] sck_s;
    logic [1:0] si_s;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cs_s  <= 3'h7;
            sck_s <= 3'h0;
            si_s  <= 2'h0;
        end else begin
            cs_s  <= {cs_s[1:0], cs_n};
            sck_s <= {sck_s[1:0], sck};
            si_s  <= {si_s[0], si};
        end
    end

    wire selected = !cs_s[1];
    wire cs_rise  = cs_s[1] && !cs_s[2];
    wire sck_rise = selected && sck_s[1] && !sck_s[2];
    wire sck_fall = selected && !sck_s[1] && sck_s[2];
    wire si_bit   = si_s[1];

    // ----------------------------------------
    // receive shifter
    // ----------------------------------------
    sfcf_mode_t mode;
    logic [6:0] rx_sh;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [23:0] tail;
    logic       cfg_armed;
    logic       tx_status;
    logic [1:0] tx_idx;
    logic [7:0] tx_sh;
    logic [2:0] tx_cnt;
    logic [31:0] prog_cnt;
    logic       captured;

    wire       byte_done = sck_rise && (bit_cnt == 3'h7);
    wire [7:0] rx_byte   = {rx_sh, si_bit};
    wire [23:0] next_tail = {tail[15:0], rx_byte};
    wire       last_tail = byte_done && (byte_cnt == 3'h3);

    // ----------------------------------------
    // opcode decode and admission
    // ----------------------------------------
    sfcf_pkg::sfcf_op_t dec_op;

    always_comb begin
        unique case (rx_byte)
            sfcf_pkg::OP_MAIN_READ:   dec_op = sfcf_pkg::OPC_MAIN_READ;
            sfcf_pkg::OP_CONT_LEGACY,
            sfcf_pkg::OP_CONT_LF,
            sfcf_pkg::OP_CONT_HF:     dec_op = sfcf_pkg::OPC_CONT_READ;
            sfcf_pkg::OP_BUF_READ_LF,
            sfcf_pkg::OP_BUF_READ:    dec_op = sfcf_pkg::OPC_BUF_READ;
            sfcf_pkg::OP_BUF_WRITE:   dec_op = sfcf_pkg::OPC_BUF_WRITE;
            sfcf_pkg::OP_PROG_ERASE:  dec_op = sfcf_pkg::OPC_PROG_ERASE;
            sfcf_pkg::OP_PROG_NOERA:  dec_op = sfcf_pkg::OPC_PROG_NOERA;
            sfcf_pkg::OP_PAGE_ERASE:  dec_op = sfcf_pkg::OPC_PAGE_ERASE;
            sfcf_pkg::OP_BLOCK_ERASE: dec_op = sfcf_pkg::OPC_BLK_ERASE;
            sfcf_pkg::OP_PROG_THRU:   dec_op = sfcf_pkg::OPC_PROG_THRU;
            default:                  dec_op = sfcf_pkg::OPC_NONE;
        endcase
    end

    wire is_status = rx_byte == sfcf_pkg::OP_STATUS;
    wire is_ident  = rx_byte == sfcf_pkg::OP_IDENT;
    wire is_cfg    = rx_byte == sfcf_pkg::OP_CFG_PREFIX;
    wire is_sect   = rx_byte == sfcf_pkg::OP_SECT_ERASE;
    wire is_buf_rw = dec_op == sfcf_pkg::OPC_BUF_READ || dec_op == sfcf_pkg::OPC_BUF_WRITE;
    wire prog_busy = prog_cnt != 32'h0;
    wire dev_busy  = array_busy || prog_busy;
    // the option program cycle admits status reads only
    wire only_stat = prog_busy || busy_kind == sfcf_pkg::BUSY_PROTECT;
    wire allowed   = !dev_busy
                   || is_status
                   || (!only_stat && is_ident)
                   || (!only_stat && busy_kind == sfcf_pkg::BUSY_ERASE && is_buf_rw);
    wire known     = dec_op != sfcf_pkg::OPC_NONE || is_status || is_ident || is_cfg || is_sect;
    wire opc_done  = byte_done && mode == M_OPC;

    // ----------------------------------------
    // response bytes
    // ----------------------------------------
    logic [7:0] status_byte;
    logic [7:0] id_byte;

    always_comb begin
        status_byte = 8'h00;
        status_byte[sfcf_pkg::ST_READY_BIT] = !dev_busy;
        status_byte[sfcf_pkg::ST_COMP_BIT] = comp_result;
        status_byte[sfcf_pkg::ST_DENS_LSB +: 4] = sfcf_pkg::ST_DENSITY;
        status_byte[sfcf_pkg::ST_PROTECT_BIT] = protect_on;
        status_byte[sfcf_pkg::ST_PSIZE_BIT] = page_256;
    end

    wire [1:0] next_idx = (tx_idx == sfcf_pkg::ID_LAST_INDEX) ? tx_idx : tx_idx + 2'h1;

    always_comb begin
        unique case (next_idx)
            2'h0: id_byte = sfcf_pkg::ID_MANUFACTURER;
            2'h1: id_byte = {sfcf_pkg::ID_FAMILY, sfcf_pkg::ID_DENSITY};
            2'h2: id_byte = {sfcf_pkg::ID_CELL_TECH, sfcf_pkg::ID_VERSION};
            2'h3: id_byte = sfcf_pkg::ID_EXT_LENGTH;
        endcase
    end

    // after the length byte the line stays at zero, no extended data
    wire [7:0] next_tx = tx_status ? status_byte
                       : (tx_idx == sfcf_pkg::ID_LAST_INDEX) ? 8'h00 : id_byte;

    // ----------------------------------------
    // frame state
    // ----------------------------------------
    sfcf_mode_t next_mode;

    always_comb begin
        next_mode = mode;
        unique case (mode)
            M_OPC: begin
                if (byte_done) begin
                    if (!allowed || !known) begin
                        next_mode = M_SKIP;
                    end else if (is_status || is_ident) begin
                        next_mode = M_TX;
                    end else if (is_cfg) begin
                        next_mode = M_CFG;
                    end else if (is_sect) begin
                        next_mode = M_CE;
                    end else begin
                        next_mode = M_BODY;
                    end
                end
            end
            M_CFG: begin
                // any bit past the fourth byte spoils the sequence
                if (cfg_armed && sck_rise) begin
                    next_mode = M_SKIP;
                end else if (last_tail && next_tail != sfcf_pkg::SEQ_CFG_TAIL) begin
                    next_mode = M_SKIP;
                end
            end
            M_CE: begin
                if (last_tail) begin
                    next_mode = M_BODY;
                end
            end
            M_BODY, M_TX, M_SKIP: begin
                next_mode = mode;
            end
            default: begin
                next_mode = M_SKIP;
            end
        endcase
    end

    wire cfg_hit   = mode == M_CFG && last_tail && next_tail == sfcf_pkg::SEQ_CFG_TAIL;
    wire chip_hit  = next_tail == sfcf_pkg::SEQ_CHIP_TAIL;
    wire push      = byte_done && (mode == M_BODY || mode == M_CE);
    wire fifo_in_rdy;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode      <= M_OPC;
            rx_sh     <= 7'h00;
            bit_cnt   <= 3'h0;
            byte_cnt  <= 3'h0;
            tail      <= 24'h0;
            cfg_armed <= 1'b0;
        end else if (!selected) begin
            mode      <= M_OPC;
            bit_cnt   <= 3'h0;
            byte_cnt  <= 3'h0;
            cfg_armed <= 1'b0;
        end else begin
            mode <= next_mode;
            if (sck_rise) begin
                rx_sh   <= rx_byte[6:0];
                bit_cnt <= bit_cnt + 3'h1;
            end
            if (byte_done && mode != M_OPC) begin
                tail <= next_tail;
            end
            if (byte_done && byte_cnt != 3'h7) begin
                byte_cnt <= byte_cnt + 3'h1;
            end
            cfg_armed <= (cfg_armed && !sck_rise) || cfg_hit;
        end
    end

    // ----------------------------------------
    // command output
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_valid  <= 1'b0;
            cmd        <= '{op: sfcf_pkg::OPC_NONE, page_256: 1'b0};
            cmd_reject <= 1'b0;
        end else begin
            cmd_valid  <= 1'b0;
            cmd_reject <= opc_done && known && !allowed;
            if (opc_done && allowed && dec_op != sfcf_pkg::OPC_NONE) begin
                cmd_valid <= 1'b1;
                cmd       <= '{op: dec_op, page_256: page_256};
            end else if (mode == M_CE && last_tail) begin
                cmd_valid <= 1'b1;
                cmd       <= '{op: chip_hit ? sfcf_pkg::OPC_CHIP_ERASE
                                            : sfcf_pkg::OPC_SECT_ERASE,
                               page_256: page_256};
            end
        end
    end

    // ----------------------------------------
    // serial output, changes on falling clock
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            so        <= 1'b0;
            so_oe     <= 1'b0;
            tx_sh     <= 8'h00;
            tx_cnt    <= 3'h0;
            tx_idx    <= 2'h0;
            tx_status <= 1'b0;
        end else if (!selected || mode != M_TX) begin
            so_oe  <= 1'b0;
            so     <= 1'b0;
            tx_cnt <= 3'h0;
            tx_idx <= 2'h0;
            if (opc_done) begin
                tx_status <= is_status;
                tx_sh     <= is_status ? status_byte : sfcf_pkg::ID_MANUFACTURER;
            end
        end else if (sck_fall) begin
            so_oe  <= 1'b1;
            so     <= tx_sh[7];
            tx_cnt <= tx_cnt + 3'h1;
            if (tx_cnt == 3'h7) begin
                tx_sh  <= next_tx;
                tx_idx <= next_idx;
            end else begin
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // page size option
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prog_cnt      <= 32'h0;
            nv_pow2_write <= 1'b0;
        end else begin
            nv_pow2_write <= prog_cnt == 32'h1;
            if (cs_rise && cfg_armed && bit_cnt == 3'h0 && !prog_busy) begin
                prog_cnt <= 32'(TP_CYCLES);
            end else if (prog_busy) begin
                prog_cnt <= prog_cnt - 32'h1;
            end
        end
    end

    // a reset stands for a power cycle, so the cell is read only once after it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            captured <= 1'b0;
            page_256 <= 1'b0;
        end else if (!captured) begin
            captured <= 1'b1;
            page_256 <= nv_pow2;
        end
    end

    assign busy = dev_busy;

    // ----------------------------------------
    // body bytes toward the array side
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_overflow <= 1'b0;
        end else if (push && !fifo_in_rdy) begin
            rx_overflow <= 1'b1;
        end else if (opc_done) begin
            rx_overflow <= 1'b0;
        end
    end

    // a full buffer drops the byte: the serial host cannot be held off
    sfcf_fifo #(
        .WIDTH (8),
        .DEPTH (32)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .in_valid  (push),
        .in_ready  (fifo_in_rdy),
        .in_data   (rx_byte),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );
endmodule // sfcf_top

// file: sfcf_unused_note.sv
`timescale 1ns/1ps

// file: sfcf_props.sv
`timescale 1ns/1ps
module sfcf_props (
    input wire logic                ref_clk,
    input wire logic                resetn,
    input wire logic                cs_n,
    input wire logic                so_oe,
    input wire logic                array_busy,
    input wire logic                nv_pow2_write,
    input wire logic                page_256,
    input wire logic                busy,
    input wire logic                cmd_valid,
    input wire sfcf_pkg::sfcf_cmd_t cmd,
    input wire logic                cmd_reject,
    input wire logic                rx_valid,
    input wire logic                rx_ready,
    input wire logic [7:0]          rx_data,
    input wire logic                rx_overflow
);
    // ----------------
    // checks
    // ----------------
    logic [1:0] since_rst;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // page size may load only at the first two edges after reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) since_rst <= 2'h0;
        else if (since_rst != 2'h3) since_rst <= since_rst + 2'h1;
    end
    chk_busy_follow: assert property (array_busy |-> busy)
        else $error("busy low while array busy");
    chk_oe_release: assert property (cs_n [*4] |-> !so_oe)
        else $error("output still driven after deselect");
    chk_page_frozen: assert property (since_rst == 2'h3 |-> $stable(page_256))
        else $error("page size changed without reset");
    chk_write_pulse: assert property (nv_pow2_write |-> $past(busy) ##1 !nv_pow2_write)
        else $error("cell write not a single pulse after busy");
    chk_cycle_end: assert property ($fell(busy) && !$past(array_busy) |->
        (nv_pow2_write || $past(nv_pow2_write)) or ##1 nv_pow2_write)
        else $error("program cycle ended without cell write");
    chk_cmd_pulse: assert property (cmd_valid |-> !cmd_reject ##1 !cmd_valid)
        else $error("command pulse malformed");
    chk_reject_busy: assert property (cmd_reject |-> $past(busy) || $past(busy, 2))
        else $error("reject while idle");
    chk_cmd_hold: assert property (!cmd_valid |-> $stable(cmd))
        else $error("command changed without pulse");
    chk_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("fifo output dropped while stalled");
    chk_ovf_kept: assert property (rx_overflow && cs_n |=> rx_overflow)
        else $error("overflow cleared outside a frame");
    cover property (nv_pow2_write);
    cover property (cmd_reject);
    cover property (rx_overflow);
    cover property (cmd_valid && cmd.op == sfcf_pkg::OPC_CHIP_ERASE);
endmodule // sfcf_props

bind sfcf_top sfcf_props u_props (.ref_clk, .resetn, .cs_n, .so_oe, .array_busy,
    .nv_pow2_write, .page_256, .busy, .cmd_valid, .cmd, .cmd_reject, .rx_valid,
    .rx_ready, .rx_data, .rx_overflow);

// file: sfcf_host.sv
`timescale 1ns/1ps
module sfcf_host (
    output logic     cs_n,
    output logic     sck,
    output logic     si,
    input wire logic so,
    input wire logic so_oe
);
    logic [7:0] txq[$], rxq[$];
    // sck stands low between frames
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // one command per frame, frames never overlap
    task automatic frame(input int nrd);
        logic [7:0] b;
        logic [7:0] r;
        int i;
        cs_n = 1'b0;
        while (txq.size() > 0) begin
            b = txq.pop_front();
            for (i = 7; i >= 0; i--) begin
                si = b[i];
                #80 sck = 1'b1;
                #80 sck = 1'b0;
            end
        end
        // released line reads as z, so a silent device never matches
        for (i = 0; i < nrd; i++) begin
            si = ~si;
            #80 sck = 1'b1;
            #76 r = {r[6:0], so_oe ? so : 1'bz};
            #4 sck = 1'b0;
            if (i % 8 == 7) rxq.push_back(r);
        end
        #80 cs_n = 1'b1;
        si = ~si;
        #120;
    endtask
endmodule // sfcf_host

// file: tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic                rej;
        sfcf_pkg::sfcf_cmd_t c;
    } sfcf_exp_t;
    logic ref_clk = 0;
    logic resetn = 0;
    logic cs_n, sck, si, so, so_oe, nv_pow2_write, page_256, busy;
    logic cmd_valid, cmd_reject, rx_valid, rx_overflow;
    logic array_busy = 0;
    logic comp_result = 0, protect_on = 0;
    logic nv_pow2 = 0;
    logic rx_ready = 0;
    logic hold_rx = 0;
    logic pg = 0;
    logic [7:0] rx_data, b;
    logic [31:0] seed = 32'h49;
    sfcf_pkg::sfcf_busy_t busy_kind = sfcf_pkg::BUSY_ERASE;
    sfcf_pkg::sfcf_cmd_t cmd;
    sfcf_exp_t e;
    sfcf_exp_t eq[$];
    logic [7:0] dq[$];
    logic [7:0] opc[13] = '{8'hd2, 8'he8, 8'h03, 8'h0b, 8'hd1, 8'hd4, 8'h84, 8'h83, 8'h88,
        8'h81, 8'h50, 8'h82, 8'h7c};
    logic [3:0] ops[13] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
        4'h8, 4'ha, 4'h9};
    logic [7:0] idb[5] = '{sfcf_pkg::ID_MANUFACTURER, {sfcf_pkg::ID_FAMILY,
        sfcf_pkg::ID_DENSITY}, {sfcf_pkg::ID_CELL_TECH, sfcf_pkg::ID_VERSION},
        sfcf_pkg::ID_EXT_LENGTH, 8'h00};
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int i;

    always #10 ref_clk = ~ref_clk;

    sfcf_top #(.TP_NS(4000)) u_dut (.ref_clk, .resetn,
        .cs_n, .sck, .si, .so, .so_oe, .array_busy, .busy_kind, .comp_result,
        .protect_on, .nv_pow2, .nv_pow2_write, .page_256, .busy, .cmd_valid, .cmd,
        .cmd_reject, .rx_valid, .rx_ready, .rx_data, .rx_overflow);
    sfcf_host u_host (.cs_n, .sck, .si, .so, .so_oe);

    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] st(input logic rdy);
        return {rdy, comp_result, sfcf_pkg::ST_DENSITY, protect_on, pg};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmd_frame(input logic [7:0] op, input logic [3:0] eop, input logic rej,
        input int n);
        eq.push_back(sfcf_exp_t'({rej, eop, pg}));
        u_host.txq.push_back(op);
        repeat (n) begin
            b = 8'(rnd());
            u_host.txq.push_back(b);
            if (!rej) dq.push_back(b);
        end
        u_host.frame(0);
    endtask

    task automatic read_frame(input logic [7:0] op, input int nbits);
        u_host.rxq.delete();
        u_host.txq.push_back(op);
        u_host.frame(nbits);
    endtask

    task automatic settle();
        repeat (800) begin
            @(posedge ref_clk);
            if (eq.size() == 0 && dq.size() == 0) break;
        end
        check("queues empty", eq.size() + dq.size(), 0);
        #2;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            test_done();
        end
    end

    // the cell only ever sets, never clears
    always @(posedge ref_clk) if (nv_pow2_write === 1'b1) nv_pow2 <= 1'b1;

    always @(posedge ref_clk) begin
        #2;
        rx_ready = !hold_rx && rnd() % 2 == 1;
    end

    // negedge sampling keeps clear of the edge that updates outputs
    always @(negedge ref_clk) begin
        if (cmd_valid === 1'b1 || cmd_reject === 1'b1) begin
            e = eq.size() ? eq.pop_front() : 'x;
            check("cmd_reject", cmd_reject, e.rej);
            if (!e.rej) check("cmd", cmd, e.c);
        end
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            check("rx_data", rx_data, dq.size() ? dq.pop_front() : 'x);
    end

    // ----------------
    // scenarios
    // ----------------
    initial begin
        repeat (6) @(posedge ref_clk);
        #2 resetn = 1'b1;
        repeat (5) @(posedge ref_clk);
        #2;
        check("page_256", page_256, 1'b0);
        for (i = 0; i < 13; i++) cmd_frame(opc[i], ops[i], 1'b0, 3);
        settle();
        eq.push_back(sfcf_exp_t'({1'b0, 4'hb, pg}));
        dq = '{8'h94, 8'h80, 8'h9a};
        u_host.txq = '{8'h7c, 8'h94, 8'h80, 8'h9a};
        u_host.frame(0);
        settle();
        comp_result = 1'(rnd());
        protect_on = 1'(rnd() >> 1);
        read_frame(8'hd7, 16);
        for (i = 0; i < 2; i++) check("status", u_host.rxq[i], st(1'b1));
        read_frame(8'h9f, 40);
        for (i = 0; i < 5; i++) check("ident", u_host.rxq[i], idb[i]);
        read_frame(8'h9f, 12);
        check("so_oe cut", so_oe, 1'b0);
        $display("basic commands done");
        settle();
        array_busy = 1'b1;
        cmd_frame(8'hd4, 4'h3, 1'b0, 3);
        cmd_frame(8'h83, 4'h5, 1'b1, 3);
        read_frame(8'hd7, 8);
        check("busy status", u_host.rxq[0], st(1'b0));
        settle();
        busy_kind = sfcf_pkg::BUSY_TRANSFER;
        cmd_frame(8'hd4, 4'h3, 1'b1, 3);
        read_frame(8'h9f, 8);
        check("ident busy", u_host.rxq[0], idb[0]);
        busy_kind = sfcf_pkg::BUSY_PROTECT;
        cmd_frame(8'h9f, 4'h0, 1'b1, 0);
        settle();
        array_busy = 1'b0;
        hold_rx = 1'b1;
        cmd_frame(8'h84, 4'h4, 1'b0, 33);
        void'(dq.pop_back());
        check("rx_overflow", rx_overflow, 1'b1);
        hold_rx = 1'b0;
        settle();
        cmd_frame(8'h81, 4'h7, 1'b0, 3);
        check("overflow clear", rx_overflow, 1'b0);
        settle();
        $display("busy admission and fifo done");
        u_host.txq = '{8'h3d, 8'h2a, 8'h80, 8'ha7};
        u_host.frame(0);
        check("busy bad seq", busy, 1'b0);
        u_host.txq = '{8'h3d, 8'h2a, 8'h80, 8'ha6};
        u_host.frame(0);
        check("busy prog", busy, 1'b1);
        read_frame(8'hd7, 8);
        check("status prog", u_host.rxq[0], st(1'b0));
        repeat (300) begin
            @(posedge ref_clk);
            if (busy === 1'b0) break;
        end
        repeat (2) @(posedge ref_clk);
        #2;
        check("nv_pow2", nv_pow2, 1'b1);
        check("page kept", page_256, 1'b0);
        read_frame(8'hd7, 8);
        check("status old page", u_host.rxq[0], st(1'b1));
        @(posedge ref_clk);
        #2 resetn = 1'b0;
        repeat (3) @(posedge ref_clk);
        #2 resetn = 1'b1;
        pg = 1'b1;
        repeat (5) @(posedge ref_clk);
        #2;
        check("page new", page_256, 1'b1);
        read_frame(8'hd7, 8);
        check("status new page", u_host.rxq[0], st(1'b1));
        cmd_frame(8'h88, 4'h6, 1'b0, 3);
        settle();
        $display("page size option done");
        test_done();
    end
endmodule // tb
